// ===== dpet_channel.sv
// one switching output: modulated edge placement against the period count
`timescale 1ns/1ps
`include "dpet_map.svh"
module dpet_channel (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // timing
    input wire dpet_pkg::dpet_time_t i_cnt,
    input wire dpet_pkg::dpet_time_t i_rise,
    input wire dpet_pkg::dpet_time_t i_fall,
    input wire logic i_rise_mod_en,
    input wire logic i_rise_dir,
    input wire logic i_fall_mod_en,
    input wire logic i_fall_dir,
    input wire logic [7:0] i_mod,
    input wire logic i_disable,
    // switch drive
    output logic o_out
);
    dpet_pkg::dpet_time_t rise_eff;
    dpet_pkg::dpet_time_t fall_eff;
    logic out_nxt;

    // shift an edge by the loop value, clamped to the 10-bit range
    function automatic dpet_pkg::dpet_time_t place(input dpet_pkg::dpet_time_t base,
        input logic en, input logic dir, input logic [7:0] m);
        logic [11:0] s;
        s = {2'h0, base};
        if (en && dir) begin
            s = s + {4'h0, m}; // later
        end else if (en) begin
            s = s - {4'h0, m}; // earlier
        end
        if (en && !dir && (base < {2'h0, m})) begin
            s = 12'h000;
        end else if (s > `DPET_TIME_MAX) begin
            s = `DPET_TIME_MAX;
        end
        return s[9:0];
    endfunction

    // effective edge times
    always_comb begin
        rise_eff = place(i_rise, i_rise_mod_en, i_rise_dir, i_mod);
        fall_eff = place(i_fall, i_fall_mod_en, i_fall_dir, i_mod);
    end

    // asserted from rise count up to fall count; disable forces low
    always_comb begin
        out_nxt = (i_cnt >= rise_eff) && (i_cnt < fall_eff);
        if (i_disable) begin
            out_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_out <= 1'b0;
        end else begin
            o_out <= out_nxt;
        end
    end

    unmod_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_rise_mod_en |-> rise_eff == i_rise)
        else $error("unmodulated rise edge moved");
    dir_late_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_fall_mod_en && i_fall_dir && ({2'h0, i_fall} + {4'h0, i_mod} <= `DPET_TIME_MAX))
        |-> fall_eff == i_fall + {2'h0, i_mod})
        else $error("positive direction did not delay fall edge");
    dir_early_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rise_mod_en && !i_rise_dir && (i_rise >= {2'h0, i_mod}))
        |-> rise_eff == i_rise - {2'h0, i_mod})
        else $error("negative direction did not advance rise edge");
    edge_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_disable && i_cnt == rise_eff && rise_eff < fall_eff) |=> o_out)
        else $error("output not asserted at rise count");
endmodule // dpet_channel

// ===== dpet_gate_model.sv
// behavioural gate-driver pair: counts on-cycles of each switch drive
`timescale 1ns/1ps
module dpet_gate_model (
    // clock and window control
    input wire logic i_clk_sys,
    input wire logic i_clr,
    // switch drives from the block
    input wire logic i_gate1,
    input wire logic i_gate2,
    // on-time counts since the last clear
    output logic [15:0] o_on1_cnt,
    output logic [15:0] o_on2_cnt,
    output logic [15:0] o_both_cnt
);
    // duty is judged over whole periods, so the phase of the window does not matter
    always_ff @(posedge i_clk_sys) begin
        if (i_clr) begin
            o_on1_cnt <= 16'h0000;
            o_on2_cnt <= 16'h0000;
            o_both_cnt <= 16'h0000;
        end else begin
            o_on1_cnt <= o_on1_cnt + {15'h0000, i_gate1};
            o_on2_cnt <= o_on2_cnt + {15'h0000, i_gate2};
            // overlap tells shared timebase from half-period offset
            o_both_cnt <= o_both_cnt + {15'h0000, i_gate1 && i_gate2};
        end
    end
endmodule // dpet_gate_model

// ===== dpet_map.svh
// register offsets, field positions, reset values and timing constants of the edge-timing block
`ifndef DPET_MAP_SVH
`define DPET_MAP_SVH
`define DPET_ADDR_O1_RISE_HI 16'hFE0C
`define DPET_ADDR_O1_RISE_SET 16'hFE0D
`define DPET_ADDR_O1_FALL_HI 16'hFE0E
`define DPET_ADDR_O1_FALL_SET 16'hFE0F
`define DPET_ADDR_O2_RISE_HI 16'hFE10
`define DPET_ADDR_O2_RISE_SET 16'hFE11
`define DPET_ADDR_O2_FALL_HI 16'hFE12
`define DPET_ADDR_O2_FALL_SET 16'hFE13
`define DPET_ADDR_CFG 16'hFE14
`define DPET_SET_LSB_HI 3
`define DPET_SET_LSB_LO 2
`define DPET_SET_MOD_EN 1
`define DPET_SET_DIR 0
`define DPET_SET_WMASK 8'h0F
`define DPET_CFG_BRIDGE 4
`define DPET_CFG_FINE 3
`define DPET_CFG_DIS1 2
`define DPET_CFG_DIS2 1
`define DPET_CFG_GO 0
`define DPET_CFG_WMASK 8'h1F
`define DPET_CFG_RST 8'h06
`define DPET_REG_RST 8'h00
`define DPET_RD_NONE 8'h00
`define DPET_CLK_NS 5
`define DPET_FINE_STEP_NS 5
`define DPET_COARSE_STEP_NS 40
`define DPET_COARSE_CYC (`DPET_COARSE_STEP_NS / `DPET_CLK_NS)
`define DPET_TIME_MAX 12'h3FF
`endif

// ===== dpet_pkg.sv
// shared types of the edge-timing block
package dpet_pkg;
    typedef logic [9:0] dpet_time_t;
    typedef logic [7:0] dpet_byte_t;
    typedef enum logic [1:0] {
        DPET_MODE_INTERLEAVED = 2'h1,
        DPET_MODE_BRIDGELESS = 2'h2
    } dpet_mode_e;
endpackage

// ===== dpet_top.sv
// edge-timing registers, commit logic and period timebase for two switching outputs
`timescale 1ns/1ps
`include "dpet_map.svh"
module dpet_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register access
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr_en,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd_en,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // control loop and period
    input wire logic [7:0] i_mod_value,
    input wire dpet_pkg::dpet_time_t i_period_steps,
    // switch drives and mode indication
    output logic o_first_switch_output,
    output logic o_second_switch_output,
    output dpet_pkg::dpet_mode_e o_mode
);
    // programmed registers: index 0 o1 rise, 1 o1 fall, 2 o2 rise, 3 o2 fall
    logic [7:0] hi_r [4];
    logic [7:0] hi_nxt [4];
    logic [3:0] set_r [4];
    logic [3:0] set_nxt [4];
    logic [4:0] cfg_r;
    logic [4:0] cfg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    // committed copies that actually drive the outputs
    dpet_pkg::dpet_time_t act_time_r [4];
    dpet_pkg::dpet_time_t act_time_nxt [4];
    logic [1:0] act_mod_r [4];
    logic [1:0] act_mod_nxt [4];
    logic act_fine_r;
    logic act_fine_nxt;
    logic act_bridge_r;
    logic act_bridge_nxt;
    logic go_prev_r;
    logic commit;
    // timebase
    logic [2:0] div_r;
    logic [2:0] div_nxt;
    logic step;
    dpet_pkg::dpet_time_t cnt_r;
    dpet_pkg::dpet_time_t cnt_nxt;
    dpet_pkg::dpet_time_t cnt2;
    logic [10:0] cnt2_sum;

    // register writes; only writable bits are stored
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hi_nxt[i] = hi_r[i];
            set_nxt[i] = set_r[i];
        end
        cfg_nxt = cfg_r;
        if (i_reg_wr_en) begin
            if (i_reg_addr == `DPET_ADDR_O1_RISE_HI) begin
                hi_nxt[0] = i_reg_wdata;
            end else if (i_reg_addr == `DPET_ADDR_O1_RISE_SET) begin
                set_nxt[0] = 4'(i_reg_wdata & `DPET_SET_WMASK);
            end else if (i_reg_addr == `DPET_ADDR_O1_FALL_HI) begin
                hi_nxt[1] = i_reg_wdata;
            end else if (i_reg_addr == `DPET_ADDR_O1_FALL_SET) begin
                set_nxt[1] = 4'(i_reg_wdata & `DPET_SET_WMASK);
            end else if (i_reg_addr == `DPET_ADDR_O2_RISE_HI) begin
                hi_nxt[2] = i_reg_wdata;
            end else if (i_reg_addr == `DPET_ADDR_O2_RISE_SET) begin
                set_nxt[2] = 4'(i_reg_wdata & `DPET_SET_WMASK);
            end else if (i_reg_addr == `DPET_ADDR_O2_FALL_HI) begin
                hi_nxt[3] = i_reg_wdata;
            end else if (i_reg_addr == `DPET_ADDR_O2_FALL_SET) begin
                set_nxt[3] = 4'(i_reg_wdata & `DPET_SET_WMASK);
            end else if (i_reg_addr == `DPET_ADDR_CFG) begin
                cfg_nxt = 5'(i_reg_wdata & `DPET_CFG_WMASK);
            end
        end
    end

    // registered read; reserved bits and unmapped offsets give zero
    always_comb begin
        rvalid_nxt = i_reg_rd_en;
        rdata_nxt = rdata_r;
        if (i_reg_rd_en) begin
            if (i_reg_addr == `DPET_ADDR_O1_RISE_HI) begin
                rdata_nxt = hi_r[0];
            end else if (i_reg_addr == `DPET_ADDR_O1_RISE_SET) begin
                rdata_nxt = {4'h0, set_r[0]};
            end else if (i_reg_addr == `DPET_ADDR_O1_FALL_HI) begin
                rdata_nxt = hi_r[1];
            end else if (i_reg_addr == `DPET_ADDR_O1_FALL_SET) begin
                rdata_nxt = {4'h0, set_r[1]};
            end else if (i_reg_addr == `DPET_ADDR_O2_RISE_HI) begin
                rdata_nxt = hi_r[2];
            end else if (i_reg_addr == `DPET_ADDR_O2_RISE_SET) begin
                rdata_nxt = {4'h0, set_r[2]};
            end else if (i_reg_addr == `DPET_ADDR_O2_FALL_HI) begin
                rdata_nxt = hi_r[3];
            end else if (i_reg_addr == `DPET_ADDR_O2_FALL_SET) begin
                rdata_nxt = {4'h0, set_r[3]};
            end else if (i_reg_addr == `DPET_ADDR_CFG) begin
                rdata_nxt = {3'h0, cfg_r};
            end else begin
                rdata_nxt = `DPET_RD_NONE;
            end
        end
    end

    // commit on low-to-high of the go bit; software writes edges first
    assign commit = cfg_r[`DPET_CFG_GO] && !go_prev_r;

    // committed copies: untouched between commits so a half-written edge never shows
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            act_time_nxt[i] = act_time_r[i];
            act_mod_nxt[i] = act_mod_r[i];
            if (commit) begin
                act_time_nxt[i] = {hi_r[i], set_r[i][`DPET_SET_LSB_HI:`DPET_SET_LSB_LO]};
                act_mod_nxt[i] = {set_r[i][`DPET_SET_MOD_EN], set_r[i][`DPET_SET_DIR]};
            end
        end
        act_fine_nxt = commit ? cfg_r[`DPET_CFG_FINE] : act_fine_r;
        act_bridge_nxt = commit ? cfg_r[`DPET_CFG_BRIDGE] : act_bridge_r;
    end

    // step enable: every cycle at 5 ns, every eighth at 40 ns
    assign step = act_fine_r || (div_r == 3'(`DPET_COARSE_CYC - 1));
    always_comb begin
        div_nxt = step ? 3'h0 : div_r + 3'h1;
        cnt_nxt = cnt_r;
        if (step) begin
            cnt_nxt = (cnt_r + 10'h001 >= i_period_steps) ? 10'h000 : cnt_r + 10'h001;
        end
    end

    // interleaved: second output runs half a period behind; bridgeless shares the count
    assign cnt2_sum = {1'b0, cnt_r} + {2'h0, i_period_steps[9:1]};
    always_comb begin
        cnt2 = cnt_r;
        if (!act_bridge_r) begin
            cnt2 = (cnt2_sum >= {1'b0, i_period_steps}) ?
                10'(cnt2_sum - {1'b0, i_period_steps}) : cnt2_sum[9:0];
        end
    end
    assign o_mode = act_bridge_r ? dpet_pkg::DPET_MODE_BRIDGELESS :
        dpet_pkg::DPET_MODE_INTERLEAVED;

    // state registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < 4; i++) begin
                hi_r[i] <= `DPET_REG_RST;
                set_r[i] <= 4'h0;
                act_time_r[i] <= 10'h000;
                act_mod_r[i] <= 2'h0;
            end
            cfg_r <= 5'(`DPET_CFG_RST);
            rdata_r <= `DPET_RD_NONE;
            rvalid_r <= 1'b0;
            act_fine_r <= 1'b0;
            act_bridge_r <= 1'b0;
            go_prev_r <= 1'b0;
            div_r <= 3'h0;
            cnt_r <= 10'h000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                hi_r[i] <= hi_nxt[i];
                set_r[i] <= set_nxt[i];
                act_time_r[i] <= act_time_nxt[i];
                act_mod_r[i] <= act_mod_nxt[i];
            end
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            act_fine_r <= act_fine_nxt;
            act_bridge_r <= act_bridge_nxt;
            go_prev_r <= cfg_r[`DPET_CFG_GO];
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;

    // disable bits act at once, without waiting for a commit
    dpet_channel u_out1 (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cnt(cnt_r),
        .i_rise(act_time_r[0]),
        .i_fall(act_time_r[1]),
        .i_rise_mod_en(act_mod_r[0][1]),
        .i_rise_dir(act_mod_r[0][0]),
        .i_fall_mod_en(act_mod_r[1][1]),
        .i_fall_dir(act_mod_r[1][0]),
        .i_mod(i_mod_value),
        .i_disable(cfg_r[`DPET_CFG_DIS1]),
        .o_out(o_first_switch_output)
    );
    dpet_channel u_out2 (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cnt(cnt2),
        .i_rise(act_time_r[2]),
        .i_fall(act_time_r[3]),
        .i_rise_mod_en(act_mod_r[2][1]),
        .i_rise_dir(act_mod_r[2][0]),
        .i_fall_mod_en(act_mod_r[3][1]),
        .i_fall_dir(act_mod_r[3][0]),
        .i_mod(i_mod_value),
        .i_disable(cfg_r[`DPET_CFG_DIS2]),
        .o_out(o_second_switch_output)
    );

    o1_rise_commit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(cfg_r[`DPET_CFG_GO]) |=> act_time_r[0] == {$past(hi_r[0]), $past(set_r[0][3:2])})
        else $error("output one rise time not composed on commit");
    o1_fall_commit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(cfg_r[`DPET_CFG_GO]) |=> act_time_r[1] == {$past(hi_r[1]), $past(set_r[1][3:2])})
        else $error("output one fall time not composed on commit");
    o2_edges_commit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(cfg_r[`DPET_CFG_GO]) |=> (act_time_r[2] == {$past(hi_r[2]), $past(set_r[2][3:2])})
        && (act_time_r[3] == {$past(hi_r[3]), $past(set_r[3][3:2])}))
        else $error("output two edge times not composed on commit");
    hold_no_commit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(cfg_r[`DPET_CFG_GO] && !go_prev_r) |=> $stable(act_time_r[0]) && $stable(act_mod_r[3]))
        else $error("active settings changed without commit");
    coarse_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!act_fine_r && step) |=> (act_fine_r || !step) [*7])
        else $error("coarse step faster than eight cycles");
    fine_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (act_fine_r && i_period_steps > 10'h001) |=> cnt_r != $past(cnt_r))
        else $error("fine resolution missed a step");
    out1_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cfg_r[`DPET_CFG_DIS1] |=> !o_first_switch_output)
        else $error("output one switched while disabled");
    out2_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cfg_r[`DPET_CFG_DIS2] |=> !o_second_switch_output)
        else $error("output two switched while disabled");
    rsvd_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_reg_rd_en && i_reg_addr == `DPET_ADDR_CFG) |=> o_reg_rdata[7:5] == 3'h0)
        else $error("reserved configuration bits read nonzero");
    bridge_count_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        act_bridge_r |-> cnt2 == cnt_r)
        else $error("bridgeless mode shifted second timebase");
endmodule // dpet_top

// ===== dual_pwm_edge_timing_tb.sv
// register-level testbench of the two-output edge-timing block
`timescale 1ns/1ps
`include "dpet_map.svh"
module dual_pwm_edge_timing_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_reg_addr = 16'h0000;
    logic i_reg_wr_en = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd_en = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic [7:0] i_mod_value = 8'h00;
    dpet_pkg::dpet_time_t i_period_steps = 10'h00A;
    logic o_first_switch_output;
    logic o_second_switch_output;
    dpet_pkg::dpet_mode_e o_mode;
    logic clr = 1'b1;
    logic [15:0] on1_cnt;
    logic [15:0] on2_cnt;
    logic [15:0] both_cnt;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    int i;

    dpet_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wr_en(i_reg_wr_en), .i_reg_wdata(i_reg_wdata), .i_reg_rd_en(i_reg_rd_en),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_mod_value(i_mod_value),
        .i_period_steps(i_period_steps), .o_first_switch_output(o_first_switch_output),
        .o_second_switch_output(o_second_switch_output), .o_mode(o_mode));
    dpet_gate_model gates (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_gate1(o_first_switch_output),
        .i_gate2(o_second_switch_output), .o_on1_cnt(on1_cnt), .o_on2_cnt(on2_cnt),
        .o_both_cnt(both_cnt));

    // 200 MHz system clock
    always #2.5 i_clk_sys = ~i_clk_sys;

    // hang guard: the tests need a few thousand cycles at most
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            $display("timeout reached");
            tally_and_finish();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        i_reg_addr <= addr;
        i_reg_wdata <= data;
        i_reg_wr_en <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr_en <= 1'b0;
    endtask

    // read pulse; answer is registered at the edge that takes the strobe
    task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_reg_addr <= addr;
        i_reg_rd_en <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd_en <= 1'b0;
        #1;
        check("rvalid", {15'h0000, o_reg_rvalid}, 16'h0001);
        check("rdata", {8'h00, o_reg_rdata}, {8'h00, exp});
    endtask

    // commit: bit 0 low first so the next write gives a rising transition
    task automatic commit(input logic [7:0] cfg);
        wr(`DPET_ADDR_CFG, cfg & 8'hFE);
        wr(`DPET_ADDR_CFG, cfg | 8'h01);
    endtask

    // count on-cycles over a whole number of periods after settling
    task automatic duty(input int n, input logic [15:0] e1, input logic [15:0] e2);
        repeat (100) @(posedge i_clk_sys);
        clr <= 1'b1;
        @(posedge i_clk_sys);
        clr <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
        #1;
        check("on time one", on1_cnt, e1);
        check("on time two", on2_cnt, e2);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        // reset values, read-only reserved bits, unmapped address
        for (i = 0; i < 9; i++) begin
            rd(16'hFE0C + 16'(i), (i == 8) ? `DPET_CFG_RST : `DPET_REG_RST);
        end
        rd(16'hFE15, `DPET_RD_NONE);
        for (i = 0; i < 8; i++) begin
            wr(16'hFE0C + 16'(i), i[0] ? 8'hFF : 8'hA5);
            rd(16'hFE0C + 16'(i), i[0] ? 8'h0F : 8'hA5);
        end
        wr(`DPET_ADDR_CFG, 8'hE6);
        rd(`DPET_ADDR_CFG, 8'h06);
        check("mode after reset", {14'h0000, o_mode}, 16'h0001);
        $display("test registers done");
        // rise 2, fall 6 on both outputs, fine steps, period 10
        for (i = 0; i < 2; i++) begin
            wr(`DPET_ADDR_O1_RISE_HI + 16'(4 * i), 8'h00);
            wr(`DPET_ADDR_O1_RISE_SET + 16'(4 * i), 8'h08);
            wr(`DPET_ADDR_O1_FALL_HI + 16'(4 * i), 8'h01);
            wr(`DPET_ADDR_O1_FALL_SET + 16'(4 * i), 8'h08);
        end
        wr(`DPET_ADDR_CFG, 8'h08);
        duty(100, 16'd0, 16'd0);
        commit(8'h08);
        duty(100, 16'd40, 16'd40);
        wr(`DPET_ADDR_O1_FALL_HI, 8'h02);
        duty(100, 16'd40, 16'd40);
        commit(8'h08);
        duty(100, 16'd80, 16'd40);
        wr(`DPET_ADDR_O1_FALL_HI, 8'h01);
        commit(8'h08);
        $display("test commit done");
        // disable bits act without a commit
        wr(`DPET_ADDR_CFG, 8'h0D);
        duty(100, 16'd0, 16'd40);
        wr(`DPET_ADDR_CFG, 8'h0B);
        duty(100, 16'd40, 16'd0);
        $display("test disable done");
        // coarse steps: eight cycles per step
        commit(8'h00);
        duty(800, 16'd320, 16'd320);
        $display("test resolution done");
        // modulation by one step, later then earlier
        @(posedge i_clk_sys);
        i_mod_value <= 8'h01;
        wr(`DPET_ADDR_O1_RISE_SET, 8'h0B);
        wr(`DPET_ADDR_O2_FALL_SET, 8'h0B);
        commit(8'h08);
        duty(100, 16'd30, 16'd50);
        wr(`DPET_ADDR_O1_RISE_SET, 8'h0A);
        wr(`DPET_ADDR_O2_FALL_SET, 8'h0A);
        commit(8'h08);
        duty(100, 16'd50, 16'd30);
        check("overlap interleaved", both_cnt, 16'd0);
        $display("test modulation done");
        // bridgeless mode, both outputs on the same count with their own edges
        commit(8'h18);
        duty(100, 16'd50, 16'd30);
        check("overlap bridgeless", both_cnt, 16'd30);
        check("mode bridgeless", {14'h0000, o_mode}, 16'h0002);
        $display("test mode done");
        tally_and_finish();
    end
endmodule // dual_pwm_edge_timing_tb
